// [hw/pslm_pkg.sv]
package pslm_pkg;
  // ----------------------------------------------------------------
  // Register file indices and segment selects
  // ----------------------------------------------------------------
  localparam logic [2:0]  REG_ACCUM     = 3'h0;
  localparam logic [2:0]  REG_COUNT     = 3'h1;
  localparam logic [2:0]  REG_SRC_INDEX = 3'h6;
  localparam logic [1:0]  SEG_EXTRA     = 2'h0;
  localparam logic [1:0]  SEG_DATA      = 2'h3;
  localparam int          NUM_GPR       = 8;
  localparam int          NUM_SEG       = 4;

  // ----------------------------------------------------------------
  // Steps, offsets, reset values, flag positions
  // ----------------------------------------------------------------
  localparam logic [15:0] STEP_BYTE     = 16'h0001;
  localparam logic [15:0] STEP_WORD     = 16'h0002;
  localparam logic [15:0] PTR_SEG_OFS   = 16'h0002;
  localparam logic [15:0] COUNT_DEC     = 16'h0001;
  localparam logic [15:0] RESET_WORD    = 16'h0000;
  localparam logic [15:0] RESET_IP      = 16'h0000;
  localparam logic [15:0] RESET_FLAGS   = 16'h0000;
  localparam int          FLAG_ZERO_BIT = 6;
  localparam int          FLAG_DIR_BIT  = 10;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE     = 3'b000,
    OP_LOAD_FAR = 3'b001,
    OP_STR_LOAD = 3'b010,
    OP_LOOP     = 3'b011,
    OP_LOOP_EQ  = 3'b100,
    OP_LOOP_NE  = 3'b101,
    OP_MOVE     = 3'b110
  } pslm_op_t;

  typedef enum logic [1:0] {
    OPND_REG = 2'b00,
    OPND_MEM = 2'b01,
    OPND_IMM = 2'b10,
    OPND_SEG = 2'b11
  } pslm_opnd_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_EXEC  = 3'b001,
    ST_RD_LO = 3'b010,
    ST_RD_HI = 3'b011,
    ST_WRITE = 3'b100
  } pslm_state_t;

  typedef struct packed {
    logic       lock;
    logic       seg_ovr;
    logic [1:0] seg_sel;
    logic       repeat_prefix;
  } pslm_prefix_t;

  typedef struct packed {
    pslm_op_t     op;
    logic         word;
    pslm_prefix_t pfx;
    pslm_opnd_t   src_kind;
    pslm_opnd_t   dst_kind;
    logic [2:0]   src_idx;
    logic [2:0]   dst_idx;
    logic [15:0]  imm;
    logic [7:0]   short_displacement;
    logic [15:0]  effective_addr;
    logic [15:0]  next_ip;
  } pslm_dec_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        word;
    logic [1:0]  seg_sel;
    logic [15:0] offset;
    logic [15:0] wdata;
  } pslm_mem_req_t;
endpackage

// [hw/pslm_gpr.sv]
module pslm_gpr
  import pslm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wa_en,
  input  wire logic [2:0]  wa_idx,
  input  wire logic        wa_byte,
  input  wire logic [15:0] wa_data,
  input  wire logic        wb_en,
  input  wire logic [2:0]  wb_idx,
  input  wire logic [15:0] wb_data,
  input  wire logic [2:0]  rd_idx,
  input  wire logic        rd_byte,
  output logic      [15:0] rd_data,
  output logic      [15:0] accum_word,
  output logic      [15:0] count_word,
  output logic      [15:0] src_index_word
);
  logic [15:0] regs_reg  [NUM_GPR];
  logic [15:0] regs_next [NUM_GPR];
  logic [2:0]  rd_base;
  logic [2:0]  wa_base;

  // Byte index 0-3 is a low byte, 4-7 the high byte of register 0-3
  always_comb begin
    rd_base = rd_byte ? {1'b0, rd_idx[1:0]} : rd_idx;
    wa_base = wa_byte ? {1'b0, wa_idx[1:0]} : wa_idx;
    rd_data = regs_reg[rd_base];
    if (rd_byte) begin
      rd_data = rd_idx[2] ? {8'h00, regs_reg[rd_base][15:8]} : {8'h00, regs_reg[rd_base][7:0]};
    end
    for (int i = 0; i < NUM_GPR; i++) begin
      regs_next[i] = regs_reg[i];
    end
    // Port b goes first so an accumulator write on port a wins a clash
    if (wb_en) begin
      regs_next[wb_idx] = wb_data;
    end
    if (wa_en && !wa_byte) begin
      regs_next[wa_base] = wa_data;
    end else if (wa_en && wa_idx[2]) begin
      regs_next[wa_base][15:8] = wa_data[7:0];
    end else if (wa_en) begin
      regs_next[wa_base][7:0] = wa_data[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_GPR; i++) begin
        regs_reg[i] <= RESET_WORD;
      end
    end else begin
      for (int i = 0; i < NUM_GPR; i++) begin
        regs_reg[i] <= regs_next[i];
      end
    end
  end

  assign accum_word     = regs_reg[REG_ACCUM];
  assign count_word     = regs_reg[REG_COUNT];
  assign src_index_word = regs_reg[REG_SRC_INDEX];
endmodule

// [hw/pslm_exec.sv]
// Notes on behaviour
// RQ1 - Far pointer load: offset word to register, word at address plus two to extra segment.
// RQ2 - None of these instructions changes any flag.
// RQ3 - Bus lock output held for the whole instruction that follows the lock prefix.
// RQ4 - Lock prefix combines with segment override and repeat on one instruction.
// RQ5 - String load puts byte in accumulator low byte, word in whole accumulator.
// RQ6 - Source index steps up when direction flag is 0, down when 1.
// RQ7 - String load may repeat; each element overwrites the accumulator.
// RQ8 - Plain loop decrements count by one, branches when new count is nonzero.
// RQ9 - Taken loop adds sign-extended 8-bit displacement to instruction pointer.
// RQ10 - Loop while equal branches only when zero flag is 1 and count nonzero.
// RQ11 - Loop while not equal branches only when zero flag is 0 and count nonzero.
// RQ12 - Move copies between accumulator, registers, memory, immediates and segment registers.
// RQ13 - Move transfers byte or word as encoded, value unchanged.
// RQ14 - String step is one for bytes and two for words.
module pslm_exec
  import pslm_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire pslm_pkg::pslm_dec_t     dec_in,
  input  wire logic          dec_valid,
  output logic               dec_ready,
  input  wire logic          flags_load,
  input  wire logic [15:0]   flags_wdata,
  output logic [15:0]        flags_word,
  output pslm_pkg::pslm_mem_req_t      mem_req,
  input  wire logic          mem_ack,
  input  wire logic [15:0]   mem_rdata,
  output logic               bus_lock,
  output logic               op_done,
  output logic [15:0]        instr_pointer,
  output logic [15:0]        extra_segment_reg,
  output logic [15:0]        accum_word,
  output logic [15:0]        count_reg,
  output logic [15:0]        src_index
);
  import pslm_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pslm_state_t   state_reg, state_next;
  pslm_dec_t     op_reg, op_next;
  pslm_mem_req_t req_reg, req_next;
  logic [15:0]   seg_reg  [NUM_SEG];
  logic [15:0]   seg_next [NUM_SEG];
  logic [15:0]   ip_reg, ip_next;
  logic [15:0]   flags_reg, flags_next;
  logic          lock_reg, lock_next;
  logic          done_reg, done_next;

  logic          wa_en, wb_en, wa_byte, rd_byte;
  logic [2:0]    wa_idx, wb_idx, rd_idx;
  logic [15:0]   wa_data, wb_data, rd_data;
  logic [15:0]   cnt_dec, step, src_val, rd_val, branch_ip;
  logic [1:0]    data_seg;
  logic          zflag, dflag, loop_taken, finish;

  pslm_gpr u_gpr (
    .clk            (clk),
    .rst            (rst),
    .wa_en          (wa_en),
    .wa_idx         (wa_idx),
    .wa_byte        (wa_byte),
    .wa_data        (wa_data),
    .wb_en          (wb_en),
    .wb_idx         (wb_idx),
    .wb_data        (wb_data),
    .rd_idx         (rd_idx),
    .rd_byte        (rd_byte),
    .rd_data        (rd_data),
    .accum_word     (accum_word),
    .count_word     (count_reg),
    .src_index_word (src_index)
  );

  // ----------------------------------------------------------------
  // Operand values and branch decision
  // ----------------------------------------------------------------
  always_comb begin
    zflag     = flags_reg[FLAG_ZERO_BIT];
    dflag     = flags_reg[FLAG_DIR_BIT];
    rd_idx    = op_reg.src_idx;
    rd_byte   = ~op_reg.word;
    cnt_dec   = count_reg - COUNT_DEC;                                      // [RQ8]
    step      = op_reg.word ? STEP_WORD : STEP_BYTE;                        // [RQ14]
    data_seg  = op_reg.pfx.seg_ovr ? op_reg.pfx.seg_sel : SEG_DATA;        // [RQ4]
    branch_ip = op_reg.next_ip + {{8{op_reg.short_displacement[7]}}, op_reg.short_displacement}; // [RQ9]
    case (op_reg.src_kind)
      OPND_IMM: src_val = op_reg.imm;
      OPND_SEG: src_val = seg_reg[op_reg.src_idx[1:0]];
      default:  src_val = rd_data;
    endcase
    if (!op_reg.word) begin
      src_val = {8'h00, src_val[7:0]};                                      // [RQ13]
    end
    rd_val = op_reg.word ? mem_rdata : {8'h00, mem_rdata[7:0]};
    case (op_reg.op)
      OP_LOOP:    loop_taken = cnt_dec != RESET_WORD;                       // [RQ8]
      OP_LOOP_EQ: loop_taken = zflag && (cnt_dec != RESET_WORD);            // [RQ10]
      OP_LOOP_NE: loop_taken = !zflag && (cnt_dec != RESET_WORD);           // [RQ11]
      default:    loop_taken = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    op_next    = op_reg;
    req_next   = req_reg;
    ip_next    = ip_reg;
    flags_next = flags_reg;
    lock_next  = lock_reg;
    done_next  = 1'b0;
    finish     = 1'b0;
    for (int i = 0; i < NUM_SEG; i++) begin
      seg_next[i] = seg_reg[i];
    end
    wa_en   = 1'b0;
    wa_idx  = REG_ACCUM;
    wa_byte = 1'b0;
    wa_data = RESET_WORD;
    wb_en   = 1'b0;
    wb_idx  = REG_COUNT;
    wb_data = RESET_WORD;
    case (state_reg)
      ST_IDLE: begin
        // Flags change only between instructions, never by these ones
        if (flags_load) begin
          flags_next = flags_wdata;                                         // [RQ2]
        end
        if (dec_valid) begin
          op_next    = dec_in;
          lock_next  = dec_in.pfx.lock;                                     // [RQ3]
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        case (op_reg.op)
          OP_LOOP, OP_LOOP_EQ, OP_LOOP_NE: begin
            wb_en   = 1'b1;
            wb_idx  = REG_COUNT;
            wb_data = cnt_dec;                                              // [RQ8]
            finish  = 1'b1;
          end
          OP_LOAD_FAR: begin
            req_next   = '{1'b1, 1'b0, 1'b1, data_seg, op_reg.effective_addr, RESET_WORD}; // [RQ1]
            state_next = ST_RD_LO;
          end
          OP_STR_LOAD: begin
            // Repeated form stops once the count is spent
            if (op_reg.pfx.repeat_prefix && count_reg == RESET_WORD) begin
              finish = 1'b1;                                                // [RQ7]
            end else begin
              if (op_reg.pfx.repeat_prefix) begin
                wb_en   = 1'b1;
                wb_data = cnt_dec;                                          // [RQ7]
              end
              req_next   = '{1'b1, 1'b0, op_reg.word, data_seg, src_index, RESET_WORD}; // [RQ5]
              state_next = ST_RD_LO;
            end
          end
          OP_MOVE: begin
            if (op_reg.src_kind == OPND_MEM) begin
              req_next   = '{1'b1, 1'b0, op_reg.word, data_seg, op_reg.effective_addr, RESET_WORD}; // [RQ12]
              state_next = ST_RD_LO;
            end else if (op_reg.dst_kind == OPND_MEM) begin
              req_next   = '{1'b1, 1'b1, op_reg.word, data_seg, op_reg.effective_addr, src_val}; // [RQ12]
              state_next = ST_WRITE;
            end else if (op_reg.dst_kind == OPND_SEG) begin
              seg_next[op_reg.dst_idx[1:0]] = src_val;                      // [RQ12]
              finish = 1'b1;
            end else begin
              wa_en   = 1'b1;
              wa_idx  = op_reg.dst_idx;
              wa_byte = ~op_reg.word;
              wa_data = src_val;                                            // [RQ13]
              finish  = 1'b1;
            end
          end
          default: finish = 1'b1;
        endcase
      end
      ST_RD_LO: begin
        if (mem_ack) begin
          req_next.valid = 1'b0;
          case (op_reg.op)
            OP_LOAD_FAR: begin
              wa_en      = 1'b1;
              wa_idx     = op_reg.dst_idx;
              wa_data    = mem_rdata;                                       // [RQ1]
              req_next   = '{1'b1, 1'b0, 1'b1, data_seg, op_reg.effective_addr + PTR_SEG_OFS, RESET_WORD}; // [RQ1]
              state_next = ST_RD_HI;
            end
            OP_STR_LOAD: begin
              wa_en   = 1'b1;
              wa_idx  = REG_ACCUM;
              wa_byte = ~op_reg.word;
              wa_data = rd_val;                                             // [RQ5]
              wb_en   = 1'b1;
              wb_idx  = REG_SRC_INDEX;
              wb_data = dflag ? src_index - step : src_index + step;        // [RQ6]
              if (op_reg.pfx.repeat_prefix) begin
                state_next = ST_EXEC;                                       // [RQ7]
              end else begin
                finish = 1'b1;
              end
            end
            default: begin
              if (op_reg.dst_kind == OPND_SEG) begin
                seg_next[op_reg.dst_idx[1:0]] = mem_rdata;                  // [RQ12]
              end else begin
                wa_en   = 1'b1;
                wa_idx  = op_reg.dst_idx;
                wa_byte = ~op_reg.word;
                wa_data = rd_val;                                           // [RQ13]
              end
              finish = 1'b1;
            end
          endcase
        end
      end
      ST_RD_HI: begin
        if (mem_ack) begin
          req_next.valid      = 1'b0;
          seg_next[SEG_EXTRA] = mem_rdata;                                  // [RQ1]
          finish              = 1'b1;
        end
      end
      ST_WRITE: begin
        if (mem_ack) begin
          req_next.valid = 1'b0;
          finish         = 1'b1;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    if (finish) begin
      state_next = ST_IDLE;
      done_next  = 1'b1;
      lock_next  = 1'b0;                                                    // [RQ3]
      ip_next    = loop_taken ? branch_ip : op_reg.next_ip;                 // [RQ9]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      op_reg    <= '0;
      req_reg   <= '0;
      ip_reg    <= RESET_IP;
      flags_reg <= RESET_FLAGS;
      lock_reg  <= 1'b0;
      done_reg  <= 1'b0;
      for (int i = 0; i < NUM_SEG; i++) begin
        seg_reg[i] <= RESET_WORD;
      end
    end else begin
      state_reg <= state_next;
      op_reg    <= op_next;
      req_reg   <= req_next;
      ip_reg    <= ip_next;
      flags_reg <= flags_next;
      lock_reg  <= lock_next;
      done_reg  <= done_next;
      for (int i = 0; i < NUM_SEG; i++) begin
        seg_reg[i] <= seg_next[i];
      end
    end
  end

  assign dec_ready         = state_reg == ST_IDLE;
  assign flags_word        = flags_reg;
  assign mem_req           = req_reg;
  assign bus_lock          = lock_reg;
  assign op_done           = done_reg;
  assign instr_pointer     = ip_reg;
  assign extra_segment_reg = seg_reg[SEG_EXTRA];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_ptr_lo;
    state_reg == ST_RD_LO && op_reg.op == OP_LOAD_FAR && mem_ack;
  endsequence
  sequence s_ptr_hi;
    state_reg == ST_RD_HI && mem_ack;
  endsequence

  a_ptr_two_reads: assert property (s_ptr_lo |=> mem_req.valid && state_reg == ST_RD_HI // [RQ1]
    && mem_req.offset == op_reg.effective_addr + PTR_SEG_OFS) else $error("far pointer second read wrong");
  a_ptr_seg_word: assert property (s_ptr_hi |=> extra_segment_reg == $past(mem_rdata)) // [RQ1]
    else $error("far pointer segment word wrong");
  a_flags_hold: assert property (state_reg != ST_IDLE |=> flags_word == $past(flags_word)) // [RQ2]
    else $error("flags changed during instruction");
  a_lock_span: assert property (state_reg != ST_IDLE |-> bus_lock == op_reg.pfx.lock) // [RQ3]
    else $error("bus lock not held for locked instruction");
  a_prefix_seg: assert property (mem_req.valid |-> // [RQ4]
    mem_req.seg_sel == (op_reg.pfx.seg_ovr ? op_reg.pfx.seg_sel : SEG_DATA))
    else $error("segment override not applied");
  a_string_load_accum_byte: assert property (state_reg == ST_RD_LO && op_reg.op == OP_STR_LOAD && mem_ack && !op_reg.word // [RQ5]
    |=> accum_word == {$past(accum_word[15:8]), $past(mem_rdata[7:0])}) else $error("byte string load wrong");
  a_string_load_accum_step: assert property (state_reg == ST_RD_LO && op_reg.op == OP_STR_LOAD && mem_ack // [RQ6]
    |=> src_index == ($past(dflag) ? $past(src_index) - $past(step) : $past(src_index) + $past(step)))
    else $error("source index step wrong");
  a_string_load_accum_repeat: assert property (state_reg == ST_EXEC && op_reg.op == OP_STR_LOAD // [RQ7]
    && op_reg.pfx.repeat_prefix && count_reg != RESET_WORD |=> count_reg == $past(count_reg) - COUNT_DEC
    && state_reg == ST_RD_LO) else $error("repeated string load count wrong");
  a_loop_count: assert property (state_reg == ST_EXEC && op_reg.op inside {OP_LOOP, OP_LOOP_EQ, OP_LOOP_NE} // [RQ8]
    |=> count_reg == $past(count_reg) - COUNT_DEC && op_done) else $error("loop count not decremented");
  a_loop_target: assert property (state_reg == ST_EXEC && op_reg.op == OP_LOOP && count_reg != COUNT_DEC // [RQ9]
    |=> instr_pointer == $past(op_reg.next_ip) + {{8{$past(op_reg.short_displacement[7])}},
    $past(op_reg.short_displacement)}) else $error("loop target wrong");
  a_loop_while_equal_fall: assert property (state_reg == ST_EXEC && op_reg.op == OP_LOOP_EQ && !zflag // [RQ10]
    |=> instr_pointer == $past(op_reg.next_ip)) else $error("loop while equal branched with zero clear");
  a_loop_while_not_equal_fall: assert property (state_reg == ST_EXEC && op_reg.op == OP_LOOP_NE && zflag // [RQ11]
    |=> instr_pointer == $past(op_reg.next_ip)) else $error("loop while not equal branched with zero set");
  a_move_store: assert property (state_reg == ST_EXEC && op_reg.op == OP_MOVE && op_reg.src_kind != OPND_MEM // [RQ12]
    && op_reg.dst_kind == OPND_MEM |=> mem_req.write && mem_req.wdata == $past(src_val)
    && mem_req.word == $past(op_reg.word)) else $error("move store data wrong");
endmodule

// [tb/pslm_mem_model.sv]
module pslm_mem_model
  import pslm_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire pslm_pkg::pslm_mem_req_t mem_req,
  input  wire logic [2:0]              slow,
  output logic                         mem_ack,
  output logic [15:0]                  mem_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------
  // Sparse store, fixed pattern where never written
  // ------------------------------------------------
  logic [7:0] stored [logic [17:0]];
  logic [2:0] waited;

  function automatic logic [7:0] byte_at(input logic [1:0] s, input logic [15:0] a);
    if (stored.exists({s, a})) begin
      return stored[{s, a}];
    end
    return a[7:0] ^ {a[15:10], s} ^ 8'h5a;
  endfunction

  // ------------------------------------------------
  // Answer after slow extra cycles
  // ------------------------------------------------
  // Idle read data toggles so a late sample never looks right
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 16'h0000;
      waited    <= 3'h0;
    end else if (mem_req.valid && !mem_ack && waited >= slow) begin
      mem_ack   <= 1'b1;
      waited    <= 3'h0;
      mem_rdata <= {mem_req.word ? byte_at(mem_req.seg_sel, mem_req.offset + 16'h0001) : 8'ha5,
                    byte_at(mem_req.seg_sel, mem_req.offset)};
      if (mem_req.write) begin
        stored[{mem_req.seg_sel, mem_req.offset}] = mem_req.wdata[7:0];
        if (mem_req.word) begin
          stored[{mem_req.seg_sel, mem_req.offset + 16'h0001}] = mem_req.wdata[15:8];
        end
      end
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req.valid && !mem_ack) begin
        waited <= waited + 3'h1;
      end
    end
  end
endmodule

// [tb/test_pointer_string_loop_move_exec.sv]
module test_pointer_string_loop_move_exec;
  timeunit 1ns;
  timeprecision 100ps;
  import pslm_pkg::*;
  logic          clk;
  logic          rst;
  pslm_dec_t     dec_in;
  logic          dec_valid;
  logic          dec_ready;
  logic          flags_load;
  logic [15:0]   flags_wdata;
  logic [15:0]   flags_word;
  pslm_mem_req_t mem_req;
  logic          mem_ack;
  logic [15:0]   mem_rdata;
  logic          bus_lock;
  logic          op_done;
  logic [15:0]   instr_pointer;
  logic [15:0]   extra_segment_reg;
  logic [15:0]   accum_word;
  logic [15:0]   count_reg;
  logic [15:0]   src_index;
  logic [2:0]    slow;
  logic [31:0]   rng;
  logic [15:0]   e_ac, e_ct, e_si, e_xs, e_ip, e_fl;
  int            fails;
  int            samples_checked;

  pslm_exec dut_u (.clk(clk), .rst(rst), .dec_in(dec_in), .dec_valid(dec_valid), .dec_ready(dec_ready),
    .flags_load(flags_load), .flags_wdata(flags_wdata), .flags_word(flags_word), .mem_req(mem_req),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .bus_lock(bus_lock), .op_done(op_done),
    .instr_pointer(instr_pointer), .extra_segment_reg(extra_segment_reg), .accum_word(accum_word),
    .count_reg(count_reg), .src_index(src_index));
  pslm_mem_model mem_u (.clk(clk), .rst(rst), .mem_req(mem_req), .slow(slow), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  function automatic logic [15:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[15:0];
  endfunction

  function automatic logic [7:0] pat(input logic [1:0] s, input logic [15:0] a);
    return a[7:0] ^ {a[15:10], s} ^ 8'h5a;
  endfunction

  function automatic logic [15:0] rd(input logic [1:0] s, input logic [15:0] a, input logic w);
    return {w ? pat(s, a + 16'h0001) : 8'h00, pat(s, a)};
  endfunction

  function automatic pslm_dec_t mk(input pslm_op_t op, input logic w);
    logic [15:0] r;
    pslm_dec_t   d;
    r = rnd();
    d = '0;
    d.op = op;
    d.word = w;
    d.pfx.lock = r[0];
    d.pfx.seg_ovr = r[1];
    d.pfx.seg_sel = r[3:2];
    d.next_ip = rnd();
    return d;
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic put(input logic [2:0] i, input logic [15:0] v);
    if (i == REG_ACCUM) e_ac = v;
    if (i == REG_COUNT) e_ct = v;
    if (i == REG_SRC_INDEX) e_si = v;
  endtask

  task automatic regs();
    check("ip", instr_pointer, e_ip);
    check("flags", flags_word, e_fl);
    check("accum", accum_word, e_ac);
    check("count", count_reg, e_ct);
    check("src_index", src_index, e_si);
    check("extra_seg", extra_segment_reg, e_xs);
  endtask

  // Drives one instruction, waits for its end with a bound
  task automatic run(input pslm_dec_t d, input logic tk);
    int n;
    n = 0;
    e_ip = d.next_ip + (tk ? {{8{d.short_displacement[7]}}, d.short_displacement} : 16'h0000);
    check("ready", {15'h0000, dec_ready}, 16'h0001);
    slow = 3'(rnd() % 16'h0005);
    dec_in = d;
    dec_valid = 1'b1;
    @(posedge clk);
    #1;
    dec_valid = 1'b0;
    while (op_done !== 1'b1) begin
      check("lock", {15'h0000, bus_lock}, {15'h0000, d.pfx.lock});
      @(posedge clk);
      #1;
      n++;
      if (n > 300) begin
        fails++;
        report_and_stop();
      end
    end
    check("lock_end", {15'h0000, bus_lock}, 16'h0000);
    regs();
  endtask

  task automatic setreg(input logic [2:0] i, input logic [15:0] v);
    pslm_dec_t d;
    d = mk(OP_MOVE, 1'b1);
    d.src_kind = OPND_IMM;
    d.dst_idx = i;
    d.imm = v;
    put(i, v);
    run(d, 1'b0);
  endtask

  task automatic set_flags(input logic [15:0] v);
    flags_wdata = v;
    flags_load = 1'b1;
    @(posedge clk);
    #1;
    flags_load = 1'b0;
    e_fl = v;
  endtask

  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    pslm_dec_t   d;
    pslm_op_t    op;
    logic [15:0] c;
    logic [15:0] st;
    logic [1:0]  s;
    int          m;
    int          n;
    rst = 1'b1;
    dec_in = '0;
    dec_valid = 1'b0;
    flags_load = 1'b0;
    flags_wdata = 16'h0000;
    slow = 3'h0;
    rng = 32'd42464;
    fails = 0;
    samples_checked = 0;
    {e_ac, e_ct, e_si, e_xs} = {4{RESET_WORD}};
    e_ip = RESET_IP;
    e_fl = RESET_FLAGS;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    regs();
    for (int i = 0; i < 80; i++) begin
      set_flags(rnd());
      m = i / 4;
      d = mk(OP_MOVE, 1'b1);
      s = d.pfx.seg_ovr ? d.pfx.seg_sel : SEG_DATA;
      case (i % 4)
        0: begin
          op = (m % 3 == 0) ? OP_LOOP : ((m % 3 == 1) ? OP_LOOP_EQ : OP_LOOP_NE);
          c = (i < 24) ? 16'(i / 8) : rnd();
          setreg(REG_COUNT, c);
          d.op = op;
          d.short_displacement = 8'(rnd());
          e_ct = c - COUNT_DEC;
          run(d, e_ct != 16'h0000 && (op == OP_LOOP || (op == OP_LOOP_EQ) == e_fl[FLAG_ZERO_BIT]));
        end
        1: begin
          d.op = OP_LOAD_FAR;
          d.dst_idx = (m % 3 == 0) ? REG_ACCUM : ((m % 3 == 1) ? REG_COUNT : REG_SRC_INDEX);
          d.effective_addr = rnd() & 16'h7fff;
          put(d.dst_idx, rd(s, d.effective_addr, 1'b1));
          e_xs = rd(s, d.effective_addr + PTR_SEG_OFS, 1'b1);
          run(d, 1'b0);
        end
        2: begin
          d.op = OP_STR_LOAD;
          d.word = i[3];
          d.pfx.repeat_prefix = m[0];
          n = m[0] ? m % 3 : 1;
          if (m[0]) setreg(REG_COUNT, 16'(n));
          setreg(REG_SRC_INDEX, (rnd() & 16'h3fff) | 16'h0100);
          st = d.word ? STEP_WORD : STEP_BYTE;
          for (int k = 0; k < n; k++) begin
            c = rd(s, e_si, d.word);
            e_ac = d.word ? c : {e_ac[15:8], c[7:0]};
            e_si = e_fl[FLAG_DIR_BIT] ? e_si - st : e_si + st;
          end
          if (m[0]) e_ct = 16'h0000;
          run(d, 1'b0);
        end
        default: begin
          d.pfx.seg_ovr = 1'b0;
          d.dst_idx = REG_COUNT;
          // Byte form moves accumulator high byte into count high byte
          if (m % 4 == 0) begin
            d.word = m[2];
            d.src_idx = {~m[2], 2'h0};
            d.dst_idx = {~m[2], REG_COUNT[1:0]};
            e_ct = m[2] ? e_ac : {e_ac[15:8], e_ct[7:0]};
          end
          if (m % 4 == 1) begin
            d.word = i[4];
            d.src_kind = OPND_MEM;
            d.effective_addr = rnd() & 16'h7fff;
            c = rd(SEG_DATA, d.effective_addr, d.word);
            e_ac = d.word ? c : {e_ac[15:8], c[7:0]};
            d.dst_idx = REG_ACCUM;
          end
          if (m % 4 == 2) begin
            d.dst_kind = OPND_MEM;
            d.src_idx = REG_COUNT;
            d.effective_addr = 16'hf000 | (rnd() & 16'h0ffe);
            run(d, 1'b0);
            d.src_kind = OPND_MEM;
            d.dst_kind = OPND_REG;
            d.dst_idx = REG_SRC_INDEX;
            e_si = e_ct;
          end
          if (m % 4 == 3) begin
            d.dst_kind = OPND_SEG;
            d.dst_idx = {1'b0, SEG_EXTRA};
            e_xs = e_ac;
            run(d, 1'b0);
            d.src_kind = OPND_SEG;
            d.src_idx = {1'b0, SEG_EXTRA};
            d.dst_kind = OPND_REG;
            d.dst_idx = REG_COUNT;
            e_ct = e_xs;
          end
          d.next_ip = rnd();
          run(d, 1'b0);
        end
      endcase
    end
    report_and_stop();
  end
endmodule
